// file: include/psb_consts.vh
// Constants for the peripheral-to-system-bus direct path bridge
`ifndef PSB_CONSTS_VH
`define PSB_CONSTS_VH

// Register byte offsets (low address byte)
`define PSB_OFF_CTRL       8'h00
`define PSB_OFF_STAT       8'h04
`define PSB_OFF_STATE      8'h08

// Control register fields and reset value
`define PSB_CTRL_BYTE_OFF  0
`define PSB_CTRL_INT_EN    1
`define PSB_CTRL_RESET     2'h0

// Status register sticky flags (write one to clear)
`define PSB_STAT_SBERR     0
`define PSB_STAT_INVMAP    1
`define PSB_STAT_ILERR     2
`define PSB_STAT_UNFIN     3
`define PSB_STAT_RESET     4'h0

// Peripheral control-line encodings
`define PSB_PCTL_READ      2'h0
`define PSB_PCTL_ILREAD    2'h1
`define PSB_PCTL_WORD      2'h2
`define PSB_PCTL_BYTE      2'h3

// System bus commands
`define PSB_SB_READ        3'h1
`define PSB_SB_RD_INTENT   3'h2
`define PSB_SB_MWRITE      3'h3
`define PSB_SB_UMWRITE     3'h4

// System bus response codes
`define PSB_RSP_ACK        2'h0
`define PSB_RSP_RETRY      2'h1
`define PSB_RSP_ERR        2'h2

`endif

// file: logic/psb_direct_path.v
// Peripheral-initiated transfers to the system bus through the direct path
`timescale 1ns/1ps
`include "psb_consts.vh"
module psb_direct_path #(
  parameter PA_W = 18,
  parameter SA_W = 30
) (
  input  wire            hclk,
  input  wire            hresetn,
  input  wire            hsel,
  input  wire [31:0]     haddr,
  input  wire [1:0]      htrans,
  input  wire            hwrite,
  input  wire [2:0]      hsize,
  input  wire [31:0]     hwdata,
  input  wire            hready,
  output wire            hreadyout,
  output wire            hresp,
  output reg  [31:0]     hrdata,
  input  wire            per_req,
  output reg             per_grant,
  input  wire            per_bbsy,
  input  wire            per_msync,
  input  wire [1:0]      per_ctrl,
  input  wire [PA_W-1:0] per_addr,
  input  wire [15:0]     per_wdata,
  input  wire            per_buffered,
  input  wire            per_map_valid,
  output reg             per_ssync,
  output reg  [15:0]     per_rdata,
  input  wire            sb_slave_busy,
  output wire            sb_slave_retry,
  output wire            sb_valid,
  input  wire            sb_ready,
  output wire [2:0]      sb_cmd,
  output wire [SA_W-1:0] sb_addr,
  output wire [3:0]      sb_mask,
  output wire [31:0]     sb_wdata,
  input  wire            sb_rsp_valid,
  input  wire [1:0]      sb_rsp_code,
  input  wire [31:0]     sb_rdata,
  input  wire            sb_done,
  output reg             sb_err_intr
);
  localparam EW = 3 + SA_W + 4 + 32;

  localparam [3:0] S_IDLE   = 4'h0;
  localparam [3:0] S_GRANT  = 4'h1;
  localparam [3:0] S_DECODE = 4'h2;
  localparam [3:0] S_ISSUE  = 4'h3;
  localparam [3:0] S_WAIT   = 4'h4;
  localparam [3:0] S_SSYNC  = 4'h5;
  localparam [3:0] S_PAIR   = 4'h6;
  localparam [3:0] S_HOLD   = 4'h7;
  localparam [3:0] S_REJECT = 4'h8;

  reg  [3:0]      state;
  reg  [1:0]      ctl;
  reg  [PA_W-1:0] ea;
  reg  [15:0]     wdata;
  reg  [7:0]      bdata;
  reg             second;
  reg             got_ack;
  reg             locked;
  reg  [7:0]      rd_lo;
  reg  [1:0]      ctrl;
  reg  [3:0]      status;
  reg  [3:0]      evt;
  reg             ap_valid;
  reg             ap_write;
  reg  [7:0]      ap_off;
  wire            is_write;
  wire            is_byte;
  wire            split;
  wire            fill_ready;
  wire            push;
  wire [2:0]      entry_cmd;
  wire [SA_W-1:0] entry_addr;
  wire [3:0]      entry_mask;
  wire [31:0]     entry_data;
  wire [3:0]      w1c;
  wire            ack_now;

  // Byte lanes touched by one system bus transaction
  function [3:0] lane_mask;
    input [1:0] off;
    input       byte_op;
    input       upper;
    begin
      if (upper) begin
        lane_mask = 4'h1;
      end else if (byte_op) begin
        lane_mask = 4'h1 << off;
      end else begin
        lane_mask = 4'h3 << off;
      end
    end
  endfunction

  // Returned word from the selected lanes of a longword
  function [15:0] pick_word;
    input [31:0] lw;
    input [1:0]  off;
    reg   [31:0] sh;
    begin
      sh        = lw >> {off, 3'b000};
      pick_word = sh[15:0];
    end
  endfunction

  assign is_write  = ctl[1];
  assign is_byte   = (ctl == `PSB_PCTL_BYTE);
  assign split     = ~is_byte & (ea[1:0] == 2'h3);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign push      = (state == S_ISSUE);
  assign ack_now   = sb_rsp_valid & (sb_rsp_code == `PSB_RSP_ACK);

  // Lock also retries, since a second master would break the read-modify-write pair
  assign sb_slave_retry = (state == S_REJECT) | locked;

  assign entry_cmd = !is_write ? ((ctl == `PSB_PCTL_ILREAD) ? `PSB_SB_RD_INTENT : `PSB_SB_READ) :
                     (locked ? `PSB_SB_UMWRITE : `PSB_SB_MWRITE);
  assign entry_addr = {{(SA_W-PA_W+2){1'b0}}, ea[PA_W-1:2]} + {{(SA_W-1){1'b0}}, second};
  assign entry_mask = is_write ? lane_mask(ea[1:0], is_byte, second) : 4'hf;
  assign entry_data = is_byte ? {4{bdata}} :
                      (second ? {24'h00_0000, wdata[15:8]} :
                       ({16'h0000, wdata} << {ea[1:0], 3'b000}));

  psb_fifo2 #(
    .W (EW)
  ) u_req_buf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (push),
    .in_ready  (fill_ready),
    .in_data   ({entry_cmd, entry_addr, entry_mask, entry_data}),
    .out_valid (sb_valid),
    .out_ready (sb_ready),
    .out_data  ({sb_cmd, sb_addr, sb_mask, sb_wdata})
  );

  // Latch one peripheral cycle; byte offset shifts every access by one byte
  task latch_cycle;
    begin
      ctl     <= per_ctrl;
      ea      <= per_addr + {{(PA_W-1){1'b0}}, ctrl[`PSB_CTRL_BYTE_OFF]};
      wdata   <= per_wdata;
      bdata   <= per_addr[0] ? per_wdata[15:8] : per_wdata[7:0];
      second  <= 1'b0;
      got_ack <= 1'b0;
    end
  endtask

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= S_IDLE;
      ctl       <= `PSB_PCTL_READ;
      ea        <= {PA_W{1'b0}};
      wdata     <= 16'h0000;
      bdata     <= 8'h00;
      second    <= 1'b0;
      got_ack   <= 1'b0;
      locked    <= 1'b0;
      rd_lo     <= 8'h00;
      per_grant <= 1'b0;
      per_ssync <= 1'b0;
      per_rdata <= 16'h0000;
      evt       <= 4'h0;
    end else begin
      evt <= 4'h0;
      case (state)
        S_IDLE: begin
          if (per_msync) begin
            latch_cycle;
            state <= S_DECODE;
          end else if (per_req & ~per_bbsy & ~sb_slave_busy) begin
            per_grant <= 1'b1;
            state     <= S_GRANT;
          end
        end
        S_GRANT: begin
          if (per_bbsy) begin
            per_grant <= 1'b0;
            state     <= S_IDLE;
          end
        end
        S_DECODE: begin
          // Interlocked read rejected on the buffered path or when byte offset is set
          if ((ctl == `PSB_PCTL_ILREAD) & (per_buffered | ctrl[`PSB_CTRL_BYTE_OFF])) begin
            evt[`PSB_STAT_UNFIN] <= 1'b1;
            state                <= S_REJECT;
          end else if (!per_map_valid) begin
            evt[`PSB_STAT_INVMAP] <= 1'b1;
            state                 <= S_HOLD;
          end else begin
            state <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (fill_ready) begin
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (sb_rsp_valid & (sb_rsp_code == `PSB_RSP_ERR)) begin
            evt[`PSB_STAT_SBERR] <= 1'b1;
            locked               <= 1'b0;
            state                <= S_HOLD;
          end else if (sb_rsp_valid & (sb_rsp_code == `PSB_RSP_RETRY)) begin
            got_ack <= 1'b0;
            state   <= S_ISSUE;
          end else if (!is_write & ack_now) begin
            if (split & ~second) begin
              rd_lo  <= sb_rdata[31:24];
              second <= 1'b1;
              state  <= S_ISSUE;
            end else begin
              per_rdata <= split ? {sb_rdata[7:0], rd_lo} : pick_word(sb_rdata, ea[1:0]);
              per_ssync <= 1'b1;
              locked    <= (ctl == `PSB_PCTL_ILREAD);
              state     <= S_SSYNC;
            end
          end else if (is_write) begin
            if ((got_ack | ack_now) & sb_done) begin
              got_ack <= 1'b0;
              if (split & ~second) begin
                second <= 1'b1;
                state  <= S_ISSUE;
              end else begin
                per_ssync <= 1'b1;
                locked    <= 1'b0;
                state     <= S_SSYNC;
              end
            end else if (ack_now) begin
              got_ack <= 1'b1;
            end
          end
        end
        S_SSYNC: begin
          if (!per_msync) begin
            per_ssync <= 1'b0;
            state     <= locked ? S_PAIR : S_IDLE;
          end
        end
        S_PAIR: begin
          // Pair must be completed by a write while the bus stays held
          if (per_msync) begin
            latch_cycle;
            if (!per_ctrl[1]) begin
              evt[`PSB_STAT_ILERR] <= 1'b1;
              locked               <= 1'b0;
            end
            state <= S_DECODE;
          end else if (!per_bbsy) begin
            evt[`PSB_STAT_ILERR] <= 1'b1;
            locked               <= 1'b0;
            state                <= S_IDLE;
          end
        end
        S_HOLD: begin
          // Sync withheld; the master times out and drops master sync
          if (!per_msync) begin
            state <= S_IDLE;
          end
        end
        S_REJECT: begin
          if (!per_bbsy) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Register bus: zero wait states, write applied in the data phase
  assign w1c = (ap_valid & ap_write & (ap_off == `PSB_OFF_STAT)) ? hwdata[3:0] : 4'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid    <= 1'b0;
      ap_write    <= 1'b0;
      ap_off      <= 8'h00;
      ctrl        <= `PSB_CTRL_RESET;
      status      <= `PSB_STAT_RESET;
      hrdata      <= 32'h0000_0000;
      sb_err_intr <= 1'b0;
    end else begin
      ap_valid <= hsel & htrans[1] & hready;
      ap_write <= hwrite;
      ap_off   <= haddr[7:0];
      if (ap_valid & ap_write & (ap_off == `PSB_OFF_CTRL)) begin
        ctrl <= hwdata[1:0];
      end
      // New event wins over a clear in the same cycle
      status      <= (status & ~w1c) | evt;
      sb_err_intr <= (|evt) & ctrl[`PSB_CTRL_INT_EN];
      if (hsel & htrans[1] & hready & ~hwrite) begin
        case (haddr[7:0])
          `PSB_OFF_CTRL:  hrdata <= {30'h0000_0000, ctrl};
          `PSB_OFF_STAT:  hrdata <= {28'h000_0000, status};
          `PSB_OFF_STATE: hrdata <= {26'h000_0000, sb_valid, locked, state};
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// file: logic/psb_fifo2.v
// Two-entry valid/ready buffer for system bus requests
`timescale 1ns/1ps
module psb_fifo2 #(
  parameter W = 69
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem0;
  reg [W-1:0] mem1;
  reg         wr_ptr;
  reg         rd_ptr;
  reg [1:0]   count;
  wire        push;
  wire        pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = rd_ptr ? mem1 : mem0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem0   <= {W{1'b0}};
      mem1   <= {W{1'b0}};
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        if (wr_ptr) begin
          mem1 <= in_data;
        end else begin
          mem0 <= in_data;
        end
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule

// file: tb/periph_to_sysbus_direct_path_tb.sv
// Self-checking bench for the peripheral to system bus direct path
`timescale 1ns/1ps
`include "psb_consts.vh"
module periph_to_sysbus_direct_path_tb;
  reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ok;
  reg  [31:0] haddr = 32'h0, hwdata = 32'h0, sb_rdata = 32'h0, q;
  reg  [1:0]  htrans = 2'h0, sb_rsp_code = 2'h0, code = 2'h0, c;
  reg  [2:0]  hsize = 3'h2;
  reg         per_buffered = 1'b0, per_map_valid = 1'b1, sb_slave_busy = 1'b0, sb_ready = 1'b0;
  reg         sb_rsp_valid = 1'b0, sb_done = 1'b0, off = 1'b0, il = 1'b0, rtry = 1'b0;
  reg  [15:0] pq;
  reg  [17:0] a;
  reg  [68:0] log [$];
  wire        hreadyout, hresp, per_req, per_grant, per_bbsy, per_msync, per_ssync;
  wire        sb_slave_retry, sb_valid, sb_err_intr;
  wire [31:0] hrdata, sb_wdata;
  wire [1:0]  per_ctrl;
  wire [17:0] per_addr;
  wire [15:0] per_wdata, per_rdata;
  wire [2:0]  sb_cmd;
  wire [29:0] sb_addr;
  wire [3:0]  sb_mask;
  wire        hready = hreadyout;
  integer     err_count = 0, check_count = 0, n_intr = 0, cyc = 0, k, ni;
  always #2 hclk = ~hclk;
  psb_direct_path u_psb_direct_path (
    .hclk (hclk), .hresetn (hresetn), .hsel (hsel), .haddr (haddr), .htrans (htrans),
    .hwrite (hwrite), .hsize (hsize), .hwdata (hwdata), .hready (hready),
    .hreadyout (hreadyout), .hresp (hresp), .hrdata (hrdata),
    .per_req (per_req), .per_grant (per_grant), .per_bbsy (per_bbsy), .per_msync (per_msync),
    .per_ctrl (per_ctrl), .per_addr (per_addr), .per_wdata (per_wdata), .per_buffered (per_buffered),
    .per_map_valid (per_map_valid), .per_ssync (per_ssync), .per_rdata (per_rdata),
    .sb_slave_busy (sb_slave_busy), .sb_slave_retry (sb_slave_retry), .sb_valid (sb_valid),
    .sb_ready (sb_ready), .sb_cmd (sb_cmd), .sb_addr (sb_addr), .sb_mask (sb_mask),
    .sb_wdata (sb_wdata), .sb_rsp_valid (sb_rsp_valid), .sb_rsp_code (sb_rsp_code),
    .sb_rdata (sb_rdata), .sb_done (sb_done), .sb_err_intr (sb_err_intr)
  );
  psb_per_master u_psb_per_master (
    .hclk (hclk), .per_grant (per_grant), .per_ssync (per_ssync), .per_rdata (per_rdata),
    .per_req (per_req), .per_bbsy (per_bbsy), .per_msync (per_msync), .per_ctrl (per_ctrl),
    .per_addr (per_addr), .per_wdata (per_wdata)
  );
  function [31:0] rd_of(input [29:0] x);
    rd_of = {x[15:0], ~x[15:0]};
  endfunction
  function [31:0] lanes(input [3:0] m);
    lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction
  // System node: random stalls, answer one cycle after each accept
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    sb_ready <= $urandom % 3 != 0;
    sb_slave_busy <= $urandom % 5 == 0;
    sb_rsp_valid <= sb_valid && sb_ready;
    // Occasional retry makes the bridge re-issue; only the final attempt is logged
    rtry <= $urandom % 6 == 0;
    sb_rsp_code <= sb_valid && sb_ready ? (rtry ? `PSB_RSP_RETRY : code) : ~code;
    sb_done <= sb_valid && sb_ready && !rtry && sb_cmd >= `PSB_SB_MWRITE && code == `PSB_RSP_ACK;
    sb_rdata <= sb_valid && sb_ready ? rd_of(sb_addr) : $urandom;
    if (sb_valid && sb_ready && !rtry)
      log.push_back({sb_cmd, sb_addr, sb_mask, sb_wdata});
    if (sb_err_intr === 1'b1)
      n_intr <= n_intr + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (err_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task ahb(input w, input [7:0] ad, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      q = hrdata;
    end
  endtask
  // One acknowledged cycle; a word at lane 3 spans two longwords
  task automatic run(input [1:0] t, input [17:0] pa, input [15:0] d, input h);
    reg [17:0] e;
    reg [63:0] w;
    reg [7:0]  m;
    reg [68:0] x;
    integer    j;
    begin
      e = pa + off;
      w = t == `PSB_PCTL_BYTE ? (pa[0] ? d[15:8] : d[7:0]) : d;
      w = w << 8 * e[1:0];
      m = (t == `PSB_PCTL_BYTE ? 8'h01 : 8'h03) << e[1:0];
      log.delete();
      u_psb_per_master.xfer(t, pa, d, h, ok, pq);
      chk(ok, 1);
      for (j = 0; j <= (e[1:0] == 2'h3 && t != `PSB_PCTL_BYTE); j = j + 1) begin
        x = log.pop_front();
        chk(x[65:36], e[17:2] + j);
        if (t[1]) begin
          chk(x[68:66], il ? `PSB_SB_UMWRITE : `PSB_SB_MWRITE);
          chk(x[35:32], m[4*j +: 4]);
          chk(x[31:0] & lanes(m[4*j +: 4]), w[32*j +: 32] & lanes(m[4*j +: 4]));
        end else begin
          chk(x[68:66], t[0] ? `PSB_SB_RD_INTENT : `PSB_SB_READ);
          w[32*j +: 32] = rd_of(e[17:2] + j);
        end
      end
      if (!t[1])
        chk(pq, (w >> 8 * e[1:0]) & 64'hffff);
      il = t == `PSB_PCTL_ILREAD;
    end
  endtask
  initial begin
    k = $urandom(54237);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(0, `PSB_OFF_CTRL, 0);
    chk(q, `PSB_CTRL_RESET);
    ahb(0, `PSB_OFF_STAT, 0);
    chk(q, `PSB_STAT_RESET);
    ahb(0, 8'h20, 0);
    chk(q, 0);
    for (k = 0; k < 40; k = k + 1) begin
      if (k == 20) begin
        off = 1'b1;
        ahb(1, `PSB_OFF_CTRL, 32'h1);
      end
      c = k % 3;
      if (c == 2'h1) c = `PSB_PCTL_BYTE;
      a = $urandom % 18'h2_0000;
      if (c != `PSB_PCTL_BYTE) a[0] = 1'b0;
      run(c, a, $urandom, 0);
    end
    // Error kinds: read error, write error, invalid map, write error with interrupt masked
    off = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      ahb(1, `PSB_OFF_CTRL, k == 3 ? 32'h0 : 32'h2);
      code = k == 2 ? `PSB_RSP_ACK : `PSB_RSP_ERR;
      per_map_valid <= k != 2;
      ni = n_intr;
      u_psb_per_master.xfer(k[0] ? `PSB_PCTL_WORD : `PSB_PCTL_READ, 18'h100, 16'h5a3c, 0, ok, pq);
      chk(ok, 0);
      chk(n_intr - ni, k != 3);
      ahb(0, `PSB_OFF_STAT, 0);
      chk(q[1:0], k == 2 ? 2'h2 : 2'h1);
      ahb(1, `PSB_OFF_STAT, 32'hf);
      ahb(0, `PSB_OFF_STAT, 0);
      chk(q, `PSB_STAT_RESET);
    end
    code = `PSB_RSP_ACK;
    per_map_valid <= 1'b1;
    ahb(1, `PSB_OFF_CTRL, 32'h2);
    run(`PSB_PCTL_ILREAD, 18'h204, 0, 1);
    run(`PSB_PCTL_WORD, 18'h204, 16'hbeef, 0);
    run(`PSB_PCTL_ILREAD, 18'h204, 0, 1);
    u_psb_per_master.rel;
    il = 1'b0;
    repeat (3) @(posedge hclk);
    ahb(0, `PSB_OFF_STAT, 0);
    chk(q[2], 1);
    for (k = 0; k < 2; k = k + 1) begin
      ahb(1, `PSB_OFF_STAT, 32'hf);
      ahb(1, `PSB_OFF_CTRL, k ? 32'h3 : 32'h2);
      per_buffered <= k == 0;
      fork
        u_psb_per_master.xfer(`PSB_PCTL_ILREAD, 18'h204, 0, 1, ok, pq);
        begin
          repeat (12) @(posedge hclk);
          chk(sb_slave_retry, 1);
        end
      join
      chk(ok, 0);
      chk(sb_slave_retry, 1);
      u_psb_per_master.rel;
      repeat (4) @(posedge hclk);
      chk(sb_slave_retry, 0);
    end
    give_verdict;
  end
endmodule

// file: tb/psb_dp_properties.sv
// Port assertions for the direct path bridge
`timescale 1ns/1ps
`include "psb_consts.vh"
module psb_dp_props (
  input wire       hclk,
  input wire       hresetn,
  input wire       per_msync,
  input wire [1:0] per_ctrl,
  input wire       per_buffered,
  input wire       per_grant,
  input wire       per_ssync,
  input wire       sb_slave_busy,
  input wire       sb_slave_retry,
  input wire       sb_valid,
  input wire       sb_ready,
  input wire [2:0] sb_cmd,
  input wire [3:0] sb_mask,
  input wire       sb_rsp_valid,
  input wire [1:0] sb_rsp_code,
  input wire       sb_done
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_err;
    sb_rsp_valid && sb_rsp_code == `PSB_RSP_ERR;
  endsequence
  sequence s_il_rej;
    $rose(per_msync) && per_ctrl == `PSB_PCTL_ILREAD && per_buffered;
  endsequence
  a_grant_when_free: assert property ($rose(per_grant) |-> !$past(sb_slave_busy))
    else $error("grant during system transaction");
  // Write completion may trail the acknowledge
  a_ssync_cause: assert property ($rose(per_ssync) |->
    $past(sb_rsp_valid && sb_rsp_code == `PSB_RSP_ACK || sb_done)) else $error("slave sync without acknowledge");
  a_err_withhold: assert property (s_err |=> !per_ssync [*3])
    else $error("slave sync after error response");
  a_rej_retry: assert property (s_il_rej |-> ##[1:4] sb_slave_retry)
    else $error("no retry while rejected read pending");
  a_rej_no_ssync: assert property (s_il_rej |=> !per_ssync [*8])
    else $error("slave sync for rejected interlocked read");
  a_mask_lanes: assert property (sb_valid && sb_cmd >= `PSB_SB_MWRITE |->
    sb_mask inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc}) else $error("masked write with bad lanes");
  a_req_steady: assert property (sb_valid && !sb_ready |=> sb_valid && $stable(sb_cmd) && $stable(sb_mask))
    else $error("system request changed while stalled");
  a_ssync_hold: assert property (per_ssync && per_msync |=> per_ssync)
    else $error("slave sync dropped before master sync");
  a_ssync_drop: assert property (per_ssync && !per_msync |=> !per_ssync)
    else $error("slave sync held after master sync dropped");
endmodule
bind psb_direct_path psb_dp_props u_psb_dp_props (
  .hclk           (hclk),
  .hresetn        (hresetn),
  .per_msync      (per_msync),
  .per_ctrl       (per_ctrl),
  .per_buffered   (per_buffered),
  .per_grant      (per_grant),
  .per_ssync      (per_ssync),
  .sb_slave_busy  (sb_slave_busy),
  .sb_slave_retry (sb_slave_retry),
  .sb_valid       (sb_valid),
  .sb_ready       (sb_ready),
  .sb_cmd         (sb_cmd),
  .sb_mask        (sb_mask),
  .sb_rsp_valid   (sb_rsp_valid),
  .sb_rsp_code    (sb_rsp_code),
  .sb_done        (sb_done)
);

// file: tb/psb_per_master.sv
// Peripheral bus master model: arbitration, then the sync handshake
`timescale 1ns/1ps
module psb_per_master (
  input  wire        hclk,
  input  wire        per_grant,
  input  wire        per_ssync,
  input  wire [15:0] per_rdata,
  output reg         per_req = 1'b0,
  output reg         per_bbsy = 1'b0,
  output reg         per_msync = 1'b0,
  output reg  [1:0]  per_ctrl = 2'h0,
  output reg  [17:0] per_addr = 18'h0,
  output reg  [15:0] per_wdata = 16'h0
);
  // Gives up after a bounded wait, as a real sync timeout would
  task automatic xfer(input [1:0] c, input [17:0] a, input [15:0] d, input hold,
                      output ok, output [15:0] q);
    integer n;
    begin
      // Let a release from the last cycle land before looking at bus ownership
      @(posedge hclk);
      if (!per_bbsy) begin
        per_req <= 1'b1;
        n = 0;
        while (!per_grant && n < 60) begin
          @(posedge hclk);
          n = n + 1;
        end
        per_bbsy <= 1'b1;
        per_req <= 1'b0;
      end
      per_ctrl <= c;
      per_addr <= a;
      per_wdata <= d;
      @(posedge hclk);
      per_msync <= 1'b1;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 40) begin
        @(posedge hclk);
        ok = per_ssync;
        n = n + 1;
      end
      q = per_rdata;
      per_msync <= 1'b0;
      per_wdata <= ~d;
      while (per_ssync) @(posedge hclk);
      if (!hold)
        per_bbsy <= 1'b0;
    end
  endtask
  task rel;
    begin
      @(posedge hclk);
      per_bbsy <= 1'b0;
      per_addr <= ~per_addr;
    end
  endtask
endmodule
